/* hdl/sciw_top.sv */
// Serial receiver with idle-line detection, wake-up and Avalon-MM registers
// How it works
// - Idle detection runs always, never disabled.
// - Type bit picks short/long idle; sets idle flag.
// - Short idle counts every run of ones.
// - Long idle counts ones after stop only.
// - Idle interrupt enable raises request on idle.
// - Status read then data read clears idle.
// - Idle rearms only after a received frame.
// - Sleep bit suppresses receiver flags and interrupts.
// - Wake clears sleep; software may clear too.
// - Wake select: zero idle line, one address.
// - Idle line wakes receiver from sleep.
// - Frame with set MSB wakes receiver.
// - Waking frame lands in buffer, sets full.
// - Software may put receiver back to sleep.
module sciw_top
  import sciw_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic RXD,
  input wire logic [AW-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic IRQ
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_sync_q <= 2'b00;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ************************************************************
  // Bit timing and framing
  // ************************************************************
  sciw_ctrl_t ctrl_q, ctrl_d;
  logic [BAUD_W-1:0] baud_q, baud_d;
  logic tick, restart, in_frame;
  sciw_frame_t frame;

  sciw_bitclk u_bitclk (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .restart(restart),
    .div(baud_q),
    .tick(tick)
  );

  sciw_frame_rx u_frame (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .line(RXD),
    .tick(tick),
    .nine_bit(ctrl_q.nine_bit),
    .restart(restart),
    .in_frame(in_frame),
    .frame(frame)
  );

  // ************************************************************
  // Idle-line counters
  // ************************************************************
  logic [FL_W-1:0] flen, short_q, short_d, long_q, long_d;
  logic long_en_q, long_en_d;
  logic det_short, det_long, idle_det;

  assign flen = ctrl_q.nine_bit ? FRAME_LEN_9 : FRAME_LEN_8;

  // No enable on purpose: detection must keep running in every mode
  always_comb
  begin
    short_d = short_q;
    long_d = long_q;
    long_en_d = long_en_q;
    det_short = 1'b0;
    det_long = 1'b0;
    if (frame.done)
    begin
      long_en_d = 1'b1;
    end
    if (tick)
    begin
      if (!RXD)
      begin
        short_d = '0;
        long_d = '0;
        long_en_d = 1'b0;
      end
      else
      begin
        if (short_q != flen)
        begin
          short_d = short_q + 4'h1;
        end
        det_short = (short_q == flen - 4'h1);
        if (long_en_q && !in_frame && long_q != flen)
        begin
          long_d = long_q + 4'h1;
        end
        det_long = long_en_q && !in_frame && (long_q == flen - 4'h1);
      end
    end
  end

  assign idle_det = ctrl_q.idle_type_select ? det_long : det_short;

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      short_q <= '0;
      long_q <= '0;
      long_en_q <= 1'b1;
    end
    else
    begin
      short_q <= short_d;
      long_q <= long_d;
      long_en_q <= long_en_d;
    end
  end

  // ************************************************************
  // Avalon-MM slave handshake
  // ************************************************************
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_acc, rd_acc, wr_ctrl, rd_stat, rd_data;

  // One wait cycle per access; the answer is always registered
  assign wait_d = ~((AVS_READ | AVS_WRITE) & wait_q);
  assign wr_acc = AVS_WRITE & ~wait_q & AVS_BYTEENABLE[0];
  assign rd_acc = AVS_READ & ~wait_q;
  assign wr_ctrl = wr_acc & (AVS_ADDRESS == OFS_CTRL);
  assign rd_stat = rd_acc & (AVS_ADDRESS == OFS_STAT);
  assign rd_data = rd_acc & (AVS_ADDRESS == OFS_DATA);

  // ************************************************************
  // Flags, sleep and interrupts
  // ************************************************************
  logic full_q, full_d, idle_q, idle_d, ferr_q, ferr_d;
  logic armed_q, armed_d;
  logic [1:0] seen_q, seen_d;
  logic [DW-1:0] buf_q, buf_d;
  logic [IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d;
  logic irq_q, irq_d;
  logic msb, addr_wake, idle_wake, full_set, idle_set;

  assign msb = ctrl_q.nine_bit ? frame.data[DW-1] : frame.data[DW-2];
  assign addr_wake = ctrl_q.receiver_sleep & ctrl_q.wake_addr
                     & frame.done & msb;
  assign idle_wake = ctrl_q.receiver_sleep & ~ctrl_q.wake_addr
                     & idle_det;
  // Sleep gates every flag set except the frame that wakes
  assign full_set = frame.done
                    & (~ctrl_q.receiver_sleep | addr_wake);
  assign idle_set = idle_det & armed_q & ~ctrl_q.receiver_sleep;

  always_comb
  begin
    ctrl_d = ctrl_q;
    baud_d = baud_q;
    ien_d = ien_q;
    full_d = full_q;
    idle_d = idle_q;
    ferr_d = ferr_q;
    buf_d = buf_q;
    seen_d = seen_q;
    armed_d = armed_q;
    ist_d = ist_q;
    if (addr_wake || idle_wake)
    begin
      ctrl_d.receiver_sleep = 1'b0;
    end
    if (wr_ctrl)
    begin
      // Software write wins over a wake in the same cycle
      ctrl_d = sciw_ctrl_t'(AVS_WRITEDATA[CTRL_W-1:0]);
    end
    if (wr_acc && AVS_ADDRESS == OFS_IEN)
    begin
      ien_d = AVS_WRITEDATA[IRQ_W-1:0];
    end
    if (wr_acc && AVS_ADDRESS == OFS_BAUD)
    begin
      baud_d[7:0] = AVS_WRITEDATA[7:0];
    end
    if (AVS_WRITE && !wait_q && AVS_BYTEENABLE[1] &&
        AVS_ADDRESS == OFS_BAUD)
    begin
      baud_d[BAUD_W-1:8] = AVS_WRITEDATA[BAUD_W-1:8];
    end
    if (wr_acc && AVS_ADDRESS == OFS_ICLR)
    begin
      ist_d = ist_q & ~AVS_WRITEDATA[IRQ_W-1:0];
    end
    if (rd_stat)
    begin
      seen_d = {rdata_q[SB_IDLE], rdata_q[SB_FULL]};
    end
    if (rd_data)
    begin
      seen_d = 2'b00;
      if (seen_q[SB_IDLE])
      begin
        idle_d = 1'b0;
      end
      if (seen_q[SB_FULL])
      begin
        full_d = 1'b0;
      end
    end
    // Sets come last so an event never falls to a clear
    if (full_set)
    begin
      full_d = 1'b1;
      ferr_d = ~frame.stop_ok;
      buf_d = frame.data;
      armed_d = 1'b1;
      ist_d[IB_FULL] = 1'b1;
    end
    if (idle_set)
    begin
      idle_d = 1'b1;
      armed_d = 1'b0;
      if (ctrl_q.idle_irq_enable)
      begin
        ist_d[IB_IDLE] = 1'b1;
      end
    end
  end

  assign irq_d = |(ist_q & ien_q);

  // ************************************************************
  // Read data
  // ************************************************************
  always_comb
  begin
    rdata_d = '0;
    case (AVS_ADDRESS)
      OFS_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
      OFS_STAT: rdata_d[SB_BUSY:SB_FULL] = {in_frame, ctrl_q.receiver_sleep,
                                            ferr_q, idle_q, full_q};
      OFS_DATA: rdata_d[DW-1:0] = buf_q;
      OFS_ISTAT: rdata_d[IRQ_W-1:0] = ist_q;
      OFS_IEN: rdata_d[IRQ_W-1:0] = ien_q;
      OFS_BAUD: rdata_d[BAUD_W-1:0] = baud_q;
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RST;
      baud_q <= BAUD_RST;
      ien_q <= '0;
      ist_q <= '0;
      full_q <= 1'b0;
      idle_q <= 1'b0;
      ferr_q <= 1'b0;
      buf_q <= '0;
      seen_q <= 2'b00;
      armed_q <= 1'b1;
      irq_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      baud_q <= baud_d;
      ien_q <= ien_d;
      ist_q <= ist_d;
      full_q <= full_d;
      idle_q <= idle_d;
      ferr_q <= ferr_d;
      buf_q <= buf_d;
      seen_q <= seen_d;
      armed_q <= armed_d;
      irq_q <= irq_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign IRQ = irq_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!rst_n);
  sequence s_stat_seen;
    rd_stat && rdata_q[SB_IDLE];
  endsequence
  sequence s_data_read;
    rd_data && seen_q[SB_IDLE] && !idle_set;
  endsequence
  a_short_idle_set: assert property (
    !ctrl_q.idle_type_select && tick && RXD && short_q == flen - 4'h1
    && armed_q && !ctrl_q.receiver_sleep |=> idle_q)
    else $error("short idle not flagged");
  a_long_idle_count: assert property (
    $rose(idle_q) && $past(ctrl_q.idle_type_select)
    |-> $past(long_q) == $past(flen) - 4'h1 && $past(long_en_q))
    else $error("long idle flagged early");
  a_idle_irq_req: assert property (
    $rose(idle_q) && $past(ctrl_q.idle_irq_enable) && ien_q[IB_IDLE]
    |=> IRQ)
    else $error("idle interrupt missing");
  a_idle_clear_seq: assert property (
    $fell(idle_q) |-> $past(rd_data) && $past(seen_q[SB_IDLE]))
    else $error("idle cleared without read sequence");
  a_idle_rearm: assert property (
    $rose(idle_q) |-> $past(armed_q))
    else $error("idle set twice without frame");
  a_sleep_quiet: assert property (
    ctrl_q.receiver_sleep && !addr_wake |=> !$rose(full_q) && !$rose(idle_q))
    else $error("flag set while asleep");
  a_idle_wake: assert property (
    idle_wake && !wr_ctrl |=> !ctrl_q.receiver_sleep && !idle_q)
    else $error("idle line did not wake");
  a_addr_wake: assert property (
    addr_wake && !wr_ctrl |=> !ctrl_q.receiver_sleep && full_q
    && buf_q == $past(frame.data))
    else $error("address frame did not wake");
  a_sw_sleep: assert property (
    wr_ctrl && AVS_WRITEDATA[SB_FULL + 2] |=> ctrl_q.receiver_sleep)
    else $error("sleep write lost");
  a_bus_answer: assert property (
    (AVS_READ || AVS_WRITE) && wait_q |=> !AVS_WAITREQUEST ##1 wait_q)
    else $error("waitrequest not one cycle");
  a_stat_snap: assert property (
    s_stat_seen |=> seen_q[SB_IDLE])
    else $error("status read not remembered");
  a_clear_order: assert property (
    s_data_read |=> !idle_q)
    else $error("read pair did not clear idle");
endmodule

/* hdl/sciw_pkg.sv */
// Shared constants, carriers and state codes of the idle and wake-up receiver
package sciw_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam int unsigned AW = 5;
  localparam logic [AW-1:0] OFS_CTRL = 5'h00;
  localparam logic [AW-1:0] OFS_STAT = 5'h04;
  localparam logic [AW-1:0] OFS_DATA = 5'h08;
  localparam logic [AW-1:0] OFS_ISTAT = 5'h0c;
  localparam logic [AW-1:0] OFS_ICLR = 5'h10;
  localparam logic [AW-1:0] OFS_IEN = 5'h14;
  localparam logic [AW-1:0] OFS_BAUD = 5'h18;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned SB_FULL = 0;
  localparam int unsigned SB_IDLE = 1;
  localparam int unsigned SB_FERR = 2;
  localparam int unsigned SB_SLEEP = 3;
  localparam int unsigned SB_BUSY = 4;
  localparam int unsigned IB_IDLE = 0;
  localparam int unsigned IB_FULL = 1;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned DW = 9;
  localparam int unsigned BAUD_W = 16;
  localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0364;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  // ************************************************************
  // Frame lengths, start through stop
  // ************************************************************
  localparam int unsigned FL_W = 4;
  localparam logic [FL_W-1:0] FRAME_LEN_8 = 4'ha;
  localparam logic [FL_W-1:0] FRAME_LEN_9 = 4'hb;

  // ************************************************************
  // Carriers and state codes
  // ************************************************************
  typedef struct packed {
    logic nine_bit;
    logic wake_addr;
    logic receiver_sleep;
    logic idle_irq_enable;
    logic idle_type_select;
  } sciw_ctrl_t;

  typedef struct packed {
    logic done;
    logic stop_ok;
    logic [DW-1:0] data;
  } sciw_frame_t;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_START = 2'b01,
    FR_DATA = 2'b10,
    FR_STOP = 2'b11
  } sciw_fr_state_t;

endpackage

/* hdl/sciw_bitclk.sv */
// Bit-time enable divider, realigned to mid-bit at each start edge
module sciw_bitclk
  import sciw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic [BAUD_W-1:0] div,
  output logic tick
);

  logic [BAUD_W-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  // ************************************************************
  // Divider
  // ************************************************************
  // Free running between frames so idle bit times are still counted
  always_comb
  begin
    tick_d = 1'b0;
    cnt_d = cnt_q - 16'h0001;
    if (restart)
    begin
      cnt_d = {1'b0, div[BAUD_W-1:1]};
    end
    else if (cnt_q == '0)
    begin
      cnt_d = div - 16'h0001;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= BAUD_RST;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

/* hdl/sciw_frame_rx.sv */
// Character framer: start check, LSB-first data, stop sample
module sciw_frame_rx
  import sciw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line,
  input wire logic tick,
  input wire logic nine_bit,
  output logic restart,
  output logic in_frame,
  output sciw_frame_t frame
);

  sciw_fr_state_t st_q, st_d;
  logic [DW-1:0] sh_q, sh_d;
  logic [FL_W-1:0] n_q, n_d;
  sciw_frame_t fr_q, fr_d;

  // ************************************************************
  // Frame sequencer
  // ************************************************************
  always_comb
  begin
    st_d = st_q;
    sh_d = sh_q;
    n_d = n_q;
    fr_d = fr_q;
    fr_d.done = 1'b0;
    restart = 1'b0;
    case (st_q)
      FR_IDLE:
      begin
        if (!line)
        begin
          restart = 1'b1;
          st_d = FR_START;
        end
      end
      FR_START:
      begin
        // A glitch shorter than half a bit is dropped here
        if (tick)
        begin
          n_d = '0;
          st_d = line ? FR_IDLE : FR_DATA;
        end
      end
      FR_DATA:
      begin
        if (tick)
        begin
          sh_d = {line, sh_q[DW-1:1]};
          n_d = n_q + 4'h1;
          if (n_q == (nine_bit ? 4'h8 : 4'h7))
          begin
            st_d = FR_STOP;
          end
        end
      end
      FR_STOP:
      begin
        if (tick)
        begin
          fr_d.done = 1'b1;
          fr_d.stop_ok = line;
          fr_d.data = nine_bit ? sh_q : {1'b0, sh_q[DW-1:1]};
          st_d = FR_IDLE;
        end
      end
      default:
      begin
        st_d = FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= FR_IDLE;
      sh_q <= '0;
      n_q <= '0;
      fr_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      sh_q <= sh_d;
      n_q <= n_d;
      fr_q <= fr_d;
    end
  end

  assign in_frame = (st_q != FR_IDLE);
  assign frame = fr_q;

endmodule

/* testbench/sciw_tx_model.sv */
// Remote serial transmitter model driving the receive line
module sciw_tx_model
#(
  parameter int BIT_CYC = 16
)
(
  input wire logic clk,
  output logic txd
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line rests at mark level between frames
  initial txd = 1'b1;

  // ************************************************************
  // One frame of nb data bits, LSB first; returns at end of stop
  // ************************************************************
  // Callers chain frames of a burst back to back
  // Address frames carry the MSB set when a burst starts
  task automatic send(input logic [8:0] d, input int nb = 8);
    begin
      for (int i = 0; i < nb + 2; i++)
      begin
        txd <= (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i - 1];
        repeat (BIT_CYC) @(posedge clk);
      end
    end
  endtask
endmodule

/* testbench/sciw_top_tb.sv */
// Self-checking bench of the idle and wake-up receiver
module sciw_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sciw_pkg::*;

  localparam int BIT = 16;
  localparam int LIMIT = 30000;
  logic clk;
  logic rst_b;
  logic rxd;
  logic [AW-1:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic [31:0] rdata_s;
  logic waitreq;
  logic irq;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int took;

  sciw_top dut (
    .CORE_CLK(clk), .RST_B(rst_b), .RXD(rxd), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .IRQ(irq)
  );
  sciw_tx_model #(.BIT_CYC(BIT)) tx (.clk(clk), .txd(rxd));

  always #5 clk = ~clk;

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fails++;
      $display("[FAIL] cycle_limit expected below %0d seen %0d", LIMIT, cyc);
      complete_run();
    end
  end

  // ************************************************************
  // Shared helpers
  // ************************************************************
  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [AW-1:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0);
    rdata_s = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    check("bus_answer", 1'b1, n < 20);
  endtask

  task automatic rchk(input logic [AW-1:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string n);
    bus(1'b0, a, '0);
    check(n, e, rdata_s & m);
  endtask

  // Polls one status bit; reports cycles spent
  task automatic wait_stat(input int b, input logic v, input int maxc);
    int t0;
    t0 = cyc;
    do
      bus(1'b0, OFS_STAT, '0);
    while (rdata_s[b] !== v && cyc - t0 < maxc);
    took = cyc - t0;
  endtask

  task automatic irq_after(input logic e, input string n);
    repeat (2) @(posedge clk);
    check(n, e, irq);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    rchk(OFS_CTRL, '1, 32'h0, "ctrl_reset");
    rchk(OFS_BAUD, '1, 32'h364, "baud_reset");
    rchk(OFS_STAT, 32'hf, 32'h0, "stat_reset");
    rchk(OFS_IEN, '1, 32'h0, "ien_reset");
    rchk(5'h1c, '1, 32'h0, "unmapped_read");
    be <= 4'h0;
    bus(1'b1, OFS_CTRL, 32'h1f);
    be <= 4'hf;
    rchk(OFS_CTRL, '1, 32'h0, "ctrl_no_lane");
    bus(1'b1, OFS_BAUD, BIT);
    rchk(OFS_BAUD, '1, BIT, "baud_set");
    $display("test regs done");
  endtask

  task automatic t_short();
    rchk(OFS_STAT, 32'h0, 32'h0, "snap");
    rchk(OFS_DATA, 32'h0, 32'h0, "snap_clear");
    bus(1'b1, OFS_ICLR, 32'h3);
    bus(1'b1, OFS_CTRL, 32'h2);
    bus(1'b1, OFS_IEN, 32'h1);
    tx.send(8'hff);
    wait_stat(SB_IDLE, 1'b1, BIT * 12);
    check("short_idle_fast", 1'b1, took < BIT * 3);
    rchk(OFS_STAT, 32'h3, 32'h3, "stat_full_idle");
    rchk(OFS_ISTAT, 32'h3, 32'h3, "istat_both");
    rchk(OFS_DATA, '1, 32'hff, "data_ff");
    rchk(OFS_STAT, 32'h3, 32'h0, "pair_clears");
    irq_after(1'b1, "irq_raised");
    bus(1'b1, OFS_IEN, 32'h0);
    irq_after(1'b0, "irq_masked");
    bus(1'b1, OFS_IEN, 32'h1);
    irq_after(1'b1, "irq_unmasked");
    bus(1'b1, OFS_ICLR, 32'h1);
    irq_after(1'b0, "irq_cleared");
    rchk(OFS_ISTAT, 32'h1, 32'h0, "istat_cleared");
    repeat (BIT * 25) @(posedge clk);
    rchk(OFS_STAT, 32'h2, 32'h0, "no_rearm");
    $display("test short idle done");
  endtask

  task automatic t_long();
    bus(1'b1, OFS_CTRL, 32'h1);
    tx.send(8'hff);
    wait_stat(SB_IDLE, 1'b1, BIT * 14);
    check("long_not_early", 1'b1, took > BIT * 8);
    check("long_idle_set", 1'b1, rdata_s[SB_IDLE]);
    rchk(OFS_DATA, '1, 32'hff, "long_data");
    $display("test long idle done");
  endtask

  task automatic t_idle_wake();
    bus(1'b1, OFS_CTRL, 32'h0);
    fork
      begin
        tx.send(8'h11);
        tx.send(8'h22);
      end
    join_none
    repeat (BIT * 3) @(posedge clk);
    bus(1'b1, OFS_CTRL, 32'h4);
    wait fork;
    rchk(OFS_STAT, 32'hb, 32'h8, "asleep_no_flags");
    wait_stat(SB_SLEEP, 1'b0, BIT * 14);
    check("idle_wake", 1'b0, rdata_s[SB_SLEEP]);
    tx.send(8'h3c);
    rchk(OFS_STAT, 32'h1, 32'h1, "wake_full");
    rchk(OFS_DATA, '1, 32'h3c, "wake_data");
    bus(1'b1, OFS_CTRL, 32'h4);
    rchk(OFS_STAT, 32'h8, 32'h8, "resleep");
    bus(1'b1, OFS_CTRL, 32'h0);
    rchk(OFS_STAT, 32'h8, 32'h0, "sw_wake");
    $display("test idle wake done");
  endtask

  task automatic t_addr_wake();
    bus(1'b1, OFS_CTRL, 32'hc);
    repeat (BIT * 14) @(posedge clk);
    rchk(OFS_STAT, 32'h8, 32'h8, "idle_no_wake");
    tx.send(8'h05);
    rchk(OFS_STAT, 32'h9, 32'h8, "low_msb_sleeps");
    tx.send(8'h85);
    rchk(OFS_STAT, 32'h9, 32'h1, "addr_wake");
    rchk(OFS_DATA, '1, 32'h85, "addr_data");
    $display("test address wake done");
  endtask

  task automatic t_nine();
    bus(1'b1, OFS_CTRL, 32'h1c);
    tx.send(9'h0ff, 9);
    rchk(OFS_STAT, 32'h9, 32'h8, "nine_low_msb");
    tx.send(9'h180, 9);
    rchk(OFS_STAT, 32'h9, 32'h1, "nine_wake");
    rchk(OFS_DATA, '1, 32'h180, "nine_data");
    $display("test nine bit done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    addr = '0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = '0;
    be = 4'hf;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_short();
    t_long();
    t_idle_wake();
    t_addr_wake();
    t_nine();
    complete_run();
  end
endmodule
